// >>> rtl/tlb_loopback_ctl.sv
// per-channel loopback path control with an ahb-lite register slave
// Summary of operation
// - serial loopback works in every configuration except pipe
// - serial loopback switches on and off at run time per channel
// - serial loopback sends fabric tx words into rx, skipping rx buffer
// - serial output keeps carrying tx data during serial loopback
// - serial loopback moves receiver source to local transmitter; cdr re-tracks
// - reverse parallel loopback only in pcie at gen1 and gen2
// - reverse parallel loops rate match output to serializer; fabric keeps retimed rx data
// - pcie allows only reverse parallel; gt channels in pcie allow none
// - reverse parallel loopback behaves per pcie 2.0 loopback
// - reverse serial retimes rx data to tx output, copy to fabric
// - reverse serial selected only by register write, no pin
// - reverse serial uses only tx buffer; swing and post tap adjustable
`timescale 1ns/1ps
`default_nettype none
module tlb_loopback_ctl
  import tlb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // loopback requests
  input wire logic slb_pin_en,
  input wire logic pipe_lpbk_req,
  // parallel data
  input wire logic [WORD_W-1:0] tx_fab_word,
  input wire logic [WORD_W-1:0] rx_line_word,
  output logic [WORD_W-1:0] tx_line_word,
  output logic [WORD_W-1:0] rx_fab_word,
  // channel control
  output logic rx_pcs_rst,
  output logic rx_src_local,
  output logic tx_pcs_bypass,
  output logic [3:0] lpbk_mode,
  output logic [SWING_W-1:0] tx_swing,
  output logic [POST_W-1:0] tx_post_tap
);
  // bus and register state
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hreadyout_ff, nxt_hreadyout;
  logic hresp_ff, nxt_hresp;
  logic wr_pend_ff, nxt_wr_pend;
  logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
  logic ctrl_slb_ff, nxt_ctrl_slb;
  logic ctrl_rsl_ff, nxt_ctrl_rsl;
  logic cfg_pipe_ff, nxt_cfg_pipe;
  logic [1:0] cfg_rate_ff, nxt_cfg_rate;
  logic cfg_gt_ff, nxt_cfg_gt;
  logic [SWING_W-1:0] swing_ff, nxt_swing;
  logic [POST_W-1:0] post_ff, nxt_post;
  // pin synchroniser
  logic pin_s1_ff, pin_s2_ff;
  // mode control state
  tlb_state_t state_ff, nxt_state;
  tlb_mode_t act_mode_ff, nxt_act_mode;
  tlb_mode_t req_mode;
  logic [1:0] hold_cnt_ff, nxt_hold_cnt;
  logic rx_pcs_rst_ff, nxt_rx_pcs_rst;
  logic rx_src_local_ff, nxt_rx_src_local;
  logic tx_pcs_bypass_ff, nxt_tx_pcs_bypass;
  // helpers
  logic acc;
  logic slb_req;
  logic rpl_ok;
  logic [31:0] ctrl_rd, cfg_rd, txb_rd, stat_rd;

  assign acc = hsel & htrans[1] & hready;
  assign ctrl_rd = (32'(ctrl_slb_ff) << CTRL_SLB_B) | (32'(ctrl_rsl_ff) << CTRL_RSL_B);
  assign cfg_rd = (32'(cfg_pipe_ff) << CFG_PIPE_B) | (32'(cfg_rate_ff) << CFG_RATE_LSB)
    | (32'(cfg_gt_ff) << CFG_GT_B);
  assign txb_rd = (32'(swing_ff) << TXB_SWING_LSB) | (32'(post_ff) << TXB_POST_LSB);
  assign stat_rd = (32'(act_mode_ff) << STAT_MODE_LSB) | (32'(rx_pcs_rst_ff) << STAT_RST_B)
    | (32'(state_ff == ST_SETTLE) << STAT_SETL_B) | (32'(pin_s2_ff) << STAT_PIN_B)
    | (32'(pipe_lpbk_req) << STAT_PREQ_B);

  // zero wait state slave: read data is captured in the address phase,
  // so a read right behind a write to the same register sees the old value
  always_comb begin
    nxt_hreadyout = 1'b1;
    nxt_hresp = 1'b0;
    nxt_wr_pend = acc & hwrite & (hsize == SIZE_WORD);
    nxt_wr_addr = acc ? haddr[ADDR_W-1:0] : wr_addr_ff;
    nxt_hrdata = hrdata_ff;
    nxt_ctrl_slb = ctrl_slb_ff;
    nxt_ctrl_rsl = ctrl_rsl_ff;
    nxt_cfg_pipe = cfg_pipe_ff;
    nxt_cfg_rate = cfg_rate_ff;
    nxt_cfg_gt = cfg_gt_ff;
    nxt_swing = swing_ff;
    nxt_post = post_ff;
    if (acc & ~hwrite) begin
      case (haddr[ADDR_W-1:0])
        A_CTRL: nxt_hrdata = ctrl_rd;
        A_CFG: nxt_hrdata = cfg_rd;
        A_TXBUF: nxt_hrdata = txb_rd;
        A_STAT: nxt_hrdata = stat_rd;
        default: nxt_hrdata = 32'h0;
      endcase
    end
    if (wr_pend_ff) begin
      case (wr_addr_ff)
        A_CTRL: begin
          nxt_ctrl_slb = hwdata[CTRL_SLB_B];
          nxt_ctrl_rsl = hwdata[CTRL_RSL_B];
        end
        A_CFG: begin
          nxt_cfg_pipe = hwdata[CFG_PIPE_B];
          nxt_cfg_rate = hwdata[CFG_RATE_LSB +: 2];
          nxt_cfg_gt = hwdata[CFG_GT_B];
        end
        A_TXBUF: begin
          nxt_swing = hwdata[TXB_SWING_LSB +: SWING_W];
          nxt_post = hwdata[TXB_POST_LSB +: POST_W];
        end
        default: begin
          nxt_swing = swing_ff;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hrdata_ff <= 32'h0;
      hreadyout_ff <= 1'b1;
      hresp_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      ctrl_slb_ff <= CTRL_SLB_RST;
      ctrl_rsl_ff <= CTRL_RSL_RST;
      cfg_pipe_ff <= CFG_PIPE_RST;
      cfg_rate_ff <= CFG_RATE_RST;
      cfg_gt_ff <= CFG_GT_RST;
      swing_ff <= SWING_RST;
      post_ff <= POST_RST;
    end else begin
      hrdata_ff <= nxt_hrdata;
      hreadyout_ff <= nxt_hreadyout;
      hresp_ff <= nxt_hresp;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      ctrl_slb_ff <= nxt_ctrl_slb;
      ctrl_rsl_ff <= nxt_ctrl_rsl;
      cfg_pipe_ff <= nxt_cfg_pipe;
      cfg_rate_ff <= nxt_cfg_rate;
      cfg_gt_ff <= nxt_cfg_gt;
      swing_ff <= nxt_swing;
      post_ff <= nxt_post;
    end
  end

  // dedicated enable pin comes from outside the clock domain
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
    end else begin
      pin_s1_ff <= slb_pin_en;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  assign slb_req = ctrl_slb_ff | pin_s2_ff;
  assign rpl_ok = cfg_pipe_ff & (cfg_rate_ff <= RATE_GEN2) & ~cfg_gt_ff;

  always_comb begin
    req_mode = MODE_NORMAL;
    if (cfg_pipe_ff) begin
      if (rpl_ok & pipe_lpbk_req) begin
        req_mode = MODE_RPL;
      end
    end else if (ctrl_rsl_ff) begin
      req_mode = MODE_RSL;
    end else if (slb_req) begin
      req_mode = MODE_SLB;
    end
  end

  // a path change first holds the receive pcs in reset while the
  // recovered clock settles; later changes wait until the hold ends
  always_comb begin
    nxt_state = state_ff;
    nxt_act_mode = act_mode_ff;
    nxt_hold_cnt = hold_cnt_ff;
    unique case (state_ff)
      ST_RUN: begin
        if (req_mode != act_mode_ff) begin
          nxt_act_mode = req_mode;
          nxt_state = ST_SETTLE;
          nxt_hold_cnt = RST_HOLD_CYC - 2'h1;
        end
      end
      ST_SETTLE: begin
        if (hold_cnt_ff == 2'h0) begin
          nxt_state = ST_RUN;
        end else begin
          nxt_hold_cnt = hold_cnt_ff - 2'h1;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
    nxt_rx_pcs_rst = (nxt_state == ST_SETTLE);
    nxt_rx_src_local = (nxt_act_mode == MODE_SLB);
    nxt_tx_pcs_bypass = (nxt_act_mode == MODE_RSL);
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_ff <= ST_RUN;
      act_mode_ff <= MODE_NORMAL;
      hold_cnt_ff <= 2'h0;
      rx_pcs_rst_ff <= 1'b1;
      rx_src_local_ff <= 1'b0;
      tx_pcs_bypass_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      act_mode_ff <= nxt_act_mode;
      hold_cnt_ff <= nxt_hold_cnt;
      rx_pcs_rst_ff <= nxt_rx_pcs_rst;
      rx_src_local_ff <= nxt_rx_src_local;
      tx_pcs_bypass_ff <= nxt_tx_pcs_bypass;
    end
  end

  tlb_path_if pif();
  assign pif.mode = act_mode_ff;
  assign pif.tx_fab_word = tx_fab_word;
  assign pif.rx_line_word = rx_line_word;

  tlb_path_mux u_mux (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .pif(pif.path)
  );

  assign tx_line_word = pif.tx_line_word;
  assign rx_fab_word = pif.rx_fab_word;
  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign rx_pcs_rst = rx_pcs_rst_ff;
  assign rx_src_local = rx_src_local_ff;
  assign tx_pcs_bypass = tx_pcs_bypass_ff;
  assign lpbk_mode = act_mode_ff;
  assign tx_swing = swing_ff;
  assign tx_post_tap = post_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_no_slb_pipe;
    $rose(act_mode_ff == MODE_SLB) |-> !$past(cfg_pipe_ff);
  endproperty
  a_no_slb_pipe: assert property (p_no_slb_pipe) else $error("slb in pipe");
  property p_slb_follow;
    (!cfg_pipe_ff && !ctrl_rsl_ff && slb_req) [*4] |-> act_mode_ff == MODE_SLB;
  endproperty
  a_slb_follow: assert property (p_slb_follow) else $error("slb not entered");
  property p_src_local;
    (act_mode_ff == MODE_SLB) == rx_src_local_ff;
  endproperty
  a_src_local: assert property (p_src_local) else $error("rx source wrong");
  property p_rst_hold;
    $changed(act_mode_ff) |-> rx_pcs_rst_ff [*2] ##1 !rx_pcs_rst_ff;
  endproperty
  a_rst_hold: assert property (p_rst_hold) else $error("pcs reset hold wrong");
  property p_rpl_entry;
    $rose(act_mode_ff == MODE_RPL) |-> $past(rpl_ok) && $past(pipe_lpbk_req);
  endproperty
  a_rpl_entry: assert property (p_rpl_entry) else $error("illegal rpl entry");
  property p_pipe_only_rpl;
    cfg_pipe_ff [*4] |-> act_mode_ff inside {MODE_NORMAL, MODE_RPL};
  endproperty
  a_pipe_only_rpl: assert property (p_pipe_only_rpl) else $error("pipe mode wrong");
  property p_rsl_entry;
    $rose(act_mode_ff == MODE_RSL) |-> $past(ctrl_rsl_ff) && !$past(cfg_pipe_ff);
  endproperty
  a_rsl_entry: assert property (p_rsl_entry) else $error("rsl without register");
  property p_bypass;
    $rose(tx_pcs_bypass_ff) |-> act_mode_ff == MODE_RSL && rx_pcs_rst_ff;
  endproperty
  a_bypass: assert property (p_bypass) else $error("tx bypass wrong");

  c_slb: cover property ($rose(act_mode_ff == MODE_SLB));
  c_rpl: cover property ($rose(act_mode_ff == MODE_RPL));
  c_rsl: cover property ($rose(act_mode_ff == MODE_RSL));
  c_back: cover property ($fell(act_mode_ff == MODE_SLB) ##[1:8] act_mode_ff == MODE_NORMAL);
endmodule
`default_nettype wire

// >>> pkg/tlb_pkg.sv
// constants, register map and types for the loopback path control block
package tlb_pkg;
  // parallel word width of the channel
  localparam int WORD_W = 20;
  localparam int ADDR_W = 8;
  localparam int SWING_W = 6;
  localparam int POST_W = 5;
  // register byte offsets
  localparam logic [ADDR_W-1:0] A_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] A_CFG = 8'h04;
  localparam logic [ADDR_W-1:0] A_TXBUF = 8'h08;
  localparam logic [ADDR_W-1:0] A_STAT = 8'h0c;
  // field positions
  localparam int CTRL_SLB_B = 0;
  localparam int CTRL_RSL_B = 1;
  localparam int CFG_PIPE_B = 0;
  localparam int CFG_RATE_LSB = 1;
  localparam int CFG_GT_B = 3;
  localparam int TXB_SWING_LSB = 0;
  localparam int TXB_POST_LSB = 8;
  localparam int STAT_MODE_LSB = 0;
  localparam int STAT_RST_B = 4;
  localparam int STAT_SETL_B = 5;
  localparam int STAT_PIN_B = 6;
  localparam int STAT_PREQ_B = 7;
  // reset values
  localparam logic CTRL_SLB_RST = 1'b0;
  localparam logic CTRL_RSL_RST = 1'b0;
  localparam logic CFG_PIPE_RST = 1'b0;
  localparam logic [1:0] CFG_RATE_RST = 2'h0;
  localparam logic CFG_GT_RST = 1'b0;
  localparam logic [SWING_W-1:0] SWING_RST = 6'h20;
  localparam logic [POST_W-1:0] POST_RST = 5'h00;
  // pcie data rate code and ahb-lite word transfer size
  localparam logic [1:0] RATE_GEN2 = 2'h1;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  // receive pcs reset hold, parallel clock cycles
  localparam logic [1:0] RST_HOLD_CYC = 2'h2;

  typedef enum logic [3:0] {
    MODE_NORMAL = 4'h1,
    MODE_SLB = 4'h2,
    MODE_RPL = 4'h4,
    MODE_RSL = 4'h8
  } tlb_mode_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'h1,
    ST_SETTLE = 2'h2
  } tlb_state_t;
endpackage

// >>> pkg/tlb_path_if.sv
// datapath signals between the loopback controller and the path selector
`timescale 1ns/1ps
`default_nettype none
interface tlb_path_if;
  import tlb_pkg::*;
  tlb_mode_t mode;
  logic [WORD_W-1:0] tx_fab_word;
  logic [WORD_W-1:0] rx_line_word;
  logic [WORD_W-1:0] tx_line_word;
  logic [WORD_W-1:0] rx_fab_word;
  modport ctl(output mode, tx_fab_word, rx_line_word, input tx_line_word, rx_fab_word);
  modport path(input mode, tx_fab_word, rx_line_word, output tx_line_word, rx_fab_word);
endinterface
`default_nettype wire

// >>> rtl/tlb_path_mux.sv
// parallel data path selector for the normal path and the three loopback paths
`timescale 1ns/1ps
`default_nettype none
module tlb_path_mux
  import tlb_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // datapath
  tlb_path_if.path pif
);
  logic [WORD_W-1:0] rx_rt_ff, nxt_rx_rt;
  logic [WORD_W-1:0] rm_ff, nxt_rm;
  logic [WORD_W-1:0] tx_line_ff, nxt_tx_line;
  logic [WORD_W-1:0] rx_fab_ff, nxt_rx_fab;

  always_comb begin
    // retime stage stands for the clock recovery and deserializer
    nxt_rx_rt = pif.rx_line_word;
    // rate match stage, one word deep
    nxt_rm = rx_rt_ff;
    nxt_tx_line = pif.tx_fab_word;
    nxt_rx_fab = rx_rt_ff;
    unique case (pif.mode)
      MODE_SLB: begin
        nxt_rx_fab = pif.tx_fab_word;
        nxt_tx_line = pif.tx_fab_word;
      end
      MODE_RPL: begin
        nxt_tx_line = rm_ff;
      end
      MODE_RSL: begin
        nxt_tx_line = rx_rt_ff;
      end
      default: begin
        nxt_tx_line = pif.tx_fab_word;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      rx_rt_ff <= '0;
      rm_ff <= '0;
      tx_line_ff <= '0;
      rx_fab_ff <= '0;
    end else begin
      rx_rt_ff <= nxt_rx_rt;
      rm_ff <= nxt_rm;
      tx_line_ff <= nxt_tx_line;
      rx_fab_ff <= nxt_rx_fab;
    end
  end

  assign pif.tx_line_word = tx_line_ff;
  assign pif.rx_fab_word = rx_fab_ff;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  property p_slb_rx;
    pif.mode == MODE_SLB |=> rx_fab_ff == $past(pif.tx_fab_word);
  endproperty
  a_slb_rx: assert property (p_slb_rx) else $error("loopback rx word wrong");
  property p_slb_tx;
    pif.mode == MODE_SLB |=> tx_line_ff == $past(pif.tx_fab_word);
  endproperty
  a_slb_tx: assert property (p_slb_tx) else $error("serial out lost in loopback");
  property p_rpl_tx;
    pif.mode == MODE_RPL |=> tx_line_ff == $past(pif.rx_line_word, 3);
  endproperty
  a_rpl_tx: assert property (p_rpl_tx) else $error("reverse parallel word wrong");
  property p_rsl_tx;
    pif.mode == MODE_RSL |=> tx_line_ff == $past(pif.rx_line_word, 2)
      && rx_fab_ff == $past(pif.rx_line_word, 2);
  endproperty
  a_rsl_tx: assert property (p_rsl_tx) else $error("reverse serial word wrong");
  property p_normal;
    pif.mode == MODE_NORMAL |=> tx_line_ff == $past(pif.tx_fab_word)
      && rx_fab_ff == $past(pif.rx_line_word, 2);
  endproperty
  a_normal: assert property (p_normal) else $error("normal path wrong");
endmodule
`default_nettype wire

// >>> tb/tlb_far_model.sv
// far side model: fabric transmit words, remote link words, pipe loopback request
`timescale 1ns/1ps
`default_nettype none
module tlb_far_model
  import tlb_pkg::*;
#(
  // arbitrary alignment word and burst length
  parameter logic [WORD_W-1:0] ALIGN_WORD = 20'h0a5f3,
  parameter int ALIGN_N = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bench commands
  input wire logic lpbk_cmd,
  input wire logic realign,
  // words into the block
  output logic [WORD_W-1:0] tx_fab_word,
  output logic [WORD_W-1:0] rx_line_word,
  output logic pipe_lpbk_req
);
  integer seed = 32'ha93e8259;
  int align_cnt;
  always @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      align_cnt <= ALIGN_N;
      tx_fab_word <= '0;
      rx_line_word <= '0;
      pipe_lpbk_req <= 1'b0;
    end else begin
      align_cnt <= realign ? ALIGN_N : (align_cnt > 0 ? align_cnt - 1 : 0);
      tx_fab_word <= (align_cnt > 0) ? ALIGN_WORD : WORD_W'($random(seed));
      // remote words change every cycle so a stale copy never matches
      rx_line_word <= WORD_W'($random(seed));
      pipe_lpbk_req <= lpbk_cmd;
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_transceiver_loopback_path_control.sv
// self-checking bench for the loopback path control block
`timescale 1ns/1ps
`default_nettype none
module tb_transceiver_loopback_path_control
  import tlb_pkg::*;
;
  logic core_clk, sys_rst, hsel, hwrite, hreadyout, hresp, slb_pin_en, pipe_lpbk_req;
  logic [31:0] haddr, hwdata, hrdata, w;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic lpbk_cmd, realign, rd_dphase, rx_pcs_rst, rx_src_local, tx_pcs_bypass;
  logic [WORD_W-1:0] tx_fab_word, rx_line_word, tx_line_word, rx_fab_word;
  logic [WORD_W-1:0] tf, rl0, rl1, rl2, ex_tx, ex_rx;
  logic [3:0] lpbk_mode, m;
  logic [SWING_W-1:0] tx_swing;
  logic [POST_W-1:0] tx_post_tap;
  logic [31:0] rd_q[$];
  integer seed = 32'ha93e8259;
  int n_mismatch = 0;
  int num_checks = 0;
  int up_cnt, hold;
  logic [7:0] cfg_tab[5] = '{8'h01, 8'h03, 8'h05, 8'h07, 8'h09};
  logic [3:0] mode_tab[5] = '{4'h4, 4'h4, 4'h1, 4'h1, 4'h1};

  tlb_loopback_ctl u_dut (.core_clk(core_clk), .sys_rst(sys_rst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .slb_pin_en(slb_pin_en), .pipe_lpbk_req(pipe_lpbk_req), .tx_fab_word(tx_fab_word),
    .rx_line_word(rx_line_word), .tx_line_word(tx_line_word), .rx_fab_word(rx_fab_word),
    .rx_pcs_rst(rx_pcs_rst), .rx_src_local(rx_src_local), .tx_pcs_bypass(tx_pcs_bypass),
    .lpbk_mode(lpbk_mode), .tx_swing(tx_swing), .tx_post_tap(tx_post_tap));
  tlb_far_model u_far (.core_clk(core_clk), .sys_rst(sys_rst), .lpbk_cmd(lpbk_cmd),
    .realign(realign), .tx_fab_word(tx_fab_word), .rx_line_word(rx_line_word),
    .pipe_lpbk_req(pipe_lpbk_req));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // one ahb-lite single transfer; caller stands just after a rising edge
  task automatic bus_xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [2:0] sz);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    hsize <= sz;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dphase <= ~wr;
    @(posedge core_clk);
    while (hreadyout !== 1'b1) @(posedge core_clk);
    rd_dphase <= 1'b0;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    bus_xfer(1'b1, a, d, SIZE_WORD);
  endtask

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] exp);
    rd_q.push_back(exp);
    bus_xfer(1'b0, a, 32'h0, SIZE_WORD);
  endtask

  task automatic wait_mode(input logic [3:0] want);
    int n;
    n = 0;
    while (lpbk_mode !== want && n < 40) begin
      @(posedge core_clk);
      n++;
    end
    check(32'(lpbk_mode), 32'(want));
  endtask

  // read data is taken at the edge that ends its data phase
  always @(posedge core_clk) begin
    if (rd_dphase === 1'b1 && hreadyout === 1'b1) begin
      check(hrdata, rd_q.pop_front());
      check(32'(hresp), 32'h0);
    end
  end

  // path monitor: expectations from the mode seen at each edge
  always @(posedge core_clk) begin
    m = lpbk_mode;
    tf = tx_fab_word;
    rl2 = rl1;
    rl1 = rl0;
    rl0 = rx_line_word;
    #1;
    if (sys_rst) begin
      up_cnt = 0;
      hold = 0;
    end else begin
      if (lpbk_mode !== m) hold = 2;
      ex_tx = (m == MODE_RPL) ? rl2 : (m == MODE_RSL) ? rl1 : tf;
      ex_rx = (m == MODE_SLB) ? tf : rl1;
      if (up_cnt > 3) begin
        check(32'(tx_line_word), 32'(ex_tx));
        check(32'(rx_fab_word), 32'(ex_rx));
        check(32'(rx_pcs_rst), 32'(hold > 0));
        check(32'(rx_src_local), 32'(lpbk_mode === MODE_SLB));
        check(32'(tx_pcs_bypass), 32'(lpbk_mode === MODE_RSL));
      end
      if (hold > 0) hold--;
      up_cnt++;
    end
  end

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    close_out();
  end

  initial begin
    sys_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = SIZE_WORD;
    hwdata = 32'h0;
    slb_pin_en = 1'b0;
    lpbk_cmd = 1'b0;
    realign = 1'b0;
    rd_dphase = 1'b0;
    repeat (6) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    check(32'(lpbk_mode), 32'(MODE_NORMAL));
    check(32'(tx_swing), 32'(SWING_RST));
    bus_rd(A_CTRL, 32'h0);
    bus_rd(A_TXBUF, 32'(SWING_RST));
    bus_rd(8'h10, 32'h0);
    // refused writes: unmapped, read-only status, unmapped
    bus_wr(8'h1c, 32'h1);
    bus_wr(A_STAT, 32'hffffffff);
    bus_wr(8'h10, 32'h1);
    bus_rd(A_CTRL, 32'h0);
    bus_rd(A_STAT, 32'h1);
    bus_wr(A_CTRL, 32'h1);
    realign <= 1'b1;
    wait_mode(MODE_SLB);
    realign <= 1'b0;
    repeat (12) @(posedge core_clk);
    bus_rd(A_STAT, 32'h2);
    bus_wr(A_CTRL, 32'h0);
    wait_mode(MODE_NORMAL);
    slb_pin_en <= 1'b1;
    wait_mode(MODE_SLB);
    repeat (6) @(posedge core_clk);
    bus_rd(A_STAT, 32'h42);
    slb_pin_en <= 1'b0;
    wait_mode(MODE_NORMAL);
    bus_wr(A_CTRL, 32'h2);
    wait_mode(MODE_RSL);
    for (int i = 0; i < 3; i++) begin
      w = $random(seed);
      bus_wr(A_TXBUF, w);
      @(posedge core_clk);
      check(32'(tx_swing), 32'(w[5:0]));
      check(32'(tx_post_tap), 32'(w[12:8]));
      bus_rd(A_TXBUF, {19'h0, w[12:8], 2'h0, w[5:0]});
    end
    bus_wr(A_CTRL, 32'h3);
    lpbk_cmd <= 1'b1;
    repeat (8) @(posedge core_clk);
    check(32'(lpbk_mode), 32'(MODE_RSL));
    lpbk_cmd <= 1'b0;
    bus_wr(A_CTRL, 32'h1);
    wait_mode(MODE_SLB);
    bus_wr(A_CFG, 32'h1);
    wait_mode(MODE_NORMAL);
    bus_wr(A_CTRL, 32'h3);
    lpbk_cmd <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      bus_wr(A_CFG, 32'(cfg_tab[i]));
      wait_mode(mode_tab[i]);
      repeat (6) @(posedge core_clk);
      check(32'(lpbk_mode), 32'(mode_tab[i]));
    end
    bus_wr(A_CFG, 32'h3);
    wait_mode(MODE_RPL);
    repeat (6) @(posedge core_clk);
    bus_rd(A_STAT, 32'h84);
    lpbk_cmd <= 1'b0;
    wait_mode(MODE_NORMAL);
    repeat (6) @(posedge core_clk);
    close_out();
  end
endmodule
`default_nettype wire
